// ===== logic/csi_tx_port_control_defs.vh
// register map, field positions and reset values of the transmit-port control block
`ifndef CSI_TX_PORT_CONTROL_DEFS_VH
`define CSI_TX_PORT_CONTROL_DEFS_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_TX_PORT_SELECT   8'h32
`define IDX_OUTPUT_CONTROL   8'h33
`define IDX_OUTPUT_CONTROL_2 8'h34
`define IDX_TX_STATUS        8'h35
`define ADDR_W               10

// ----------------------------------------------------------------
// tx_port_select fields
// ----------------------------------------------------------------
`define SEL_WR_PORT0   0
`define SEL_WR_PORT1   1
`define SEL_READ_PORT  4
`define SEL_MASK       8'h13
`define SEL_RESET      8'h00

// ----------------------------------------------------------------
// output_control fields
// ----------------------------------------------------------------
`define CTL_ENABLE     0
`define CTL_CONT_CLK   1
`define CTL_ULP_LO     2
`define CTL_LANE_LO    4
`define CTL_INIT_CAL   6
`define CTL_MASK       8'h7f
`define CTL_RESET      8'h00

// ----------------------------------------------------------------
// output_control_two fields
// ----------------------------------------------------------------
`define CTL2_PERIODIC  0
`define CTL2_SINGLE    1
`define CTL2_INVERT    2
`define CTL2_PASS_ALL  3
`define CTL2_MASK      8'h0f
`define CTL2_RESET     8'h00

// ----------------------------------------------------------------
// status fields and calibration length
// ----------------------------------------------------------------
`define STS_PASS       0
`define STS_CAL_BUSY   2
`define STS_READ_PORT  4
`define CAL_BITS       1024
`define CAL_CNT_W      11
// index of the last bit of a sequence, one below CAL_BITS
`define CAL_LAST       11'h3ff

`endif

// ===== logic/skew_cal_gen.v
// skew-calibration sequencer for one transmit port
module skew_cal_gen (
	// clock and reset
	input  wire       i_clk,
	input  wire       i_rst_b,
	// paced link edges
	input  wire       i_link_edge,
	// settings
	input  wire       i_port_en,
	input  wire       i_init_cal_en,
	input  wire       i_single_req,
	input  wire       i_periodic_en,
	input  wire       i_invert,
	// transmitter events
	input  wire       i_frame_end,
	input  wire       i_idle,
	// results
	output wire       o_busy,
	output wire       o_hs_hold,
	output reg        o_bit,
	output reg        o_single_done
);
`include "csi_tx_port_control_defs.vh"

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_SEND = 2'b10;
	localparam [`CAL_CNT_W-1:0] LAST = `CAL_LAST;

	reg [1:0]            state_q;
	reg [`CAL_CNT_W-1:0] cnt_q;
	reg                  en_q;
	reg                  init_pend_q;
	reg                  per_pend_q;
	reg                  src_single_q;
	wire                 want;

	// the request bit still reads set while its done pulse is out; do not rerun it
	assign want      = init_pend_q | per_pend_q | (i_single_req & ~o_single_done);
	// no high-speed data until the start-up sequence is out
	assign o_hs_hold = init_pend_q;
	assign o_busy    = state_q[1];

	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q       <= ST_IDLE;
			cnt_q         <= {`CAL_CNT_W{1'b0}};
			en_q          <= 1'b0;
			init_pend_q   <= 1'b0;
			per_pend_q    <= 1'b0;
			src_single_q  <= 1'b0;
			o_bit         <= 1'b0;
			o_single_done <= 1'b0;
		end else begin
			en_q          <= i_port_en;
			o_single_done <= 1'b0;
			if (i_port_en && !en_q && i_init_cal_en)
				init_pend_q <= 1'b1;
			else if (!i_port_en)
				init_pend_q <= 1'b0;
			if (i_frame_end && i_periodic_en && i_port_en)
				per_pend_q <= 1'b1;
			else if (!i_port_en)
				per_pend_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// single and periodic wait for an idle gap; start-up never has data
					if (i_port_en && want && (i_idle || init_pend_q)) begin
						state_q      <= ST_SEND;
						cnt_q        <= {`CAL_CNT_W{1'b0}};
						src_single_q <= i_single_req & ~init_pend_q & ~per_pend_q;
						o_bit        <= i_invert;
					end
				end
				ST_SEND: begin
					if (!i_port_en) begin
						state_q <= ST_IDLE;
					end else if (i_link_edge) begin
						o_bit <= ~o_bit;
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == LAST) begin
							state_q       <= ST_IDLE;
							o_single_done <= src_single_q;
							if (init_pend_q)
								init_pend_q <= 1'b0;
							else if (!src_single_q)
								per_pend_q <= i_frame_end & i_periodic_en;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

endmodule // skew_cal_gen

// ===== logic/csi_tx_port_control.v
// transmit-port control registers with apb access and per-port calibration
// How it works
// - write-enable bit 1 lets prefixed register writes reach port 1's block.
// - write-enable bit 0 lets prefixed register writes reach port 0's block.
// - read-select bit 4 picks which port's prefixed registers are read back.
// - initial calibration bit 6 sends calibration at start-up before any data.
// - lane field 5:4 gives 00 four, 01 three, 10 two, 11 one lane.
// - field 3:2 forces LP00 on data lanes (01) or data and clock (11).
// - control bit 0 enables the output port; clear disables it.
// - pass mode bit 3 selects any-port or all-ports valid video for pass.
// - writing 1 to single bit sends one 1024-bit sequence at next idle.
// - single bit clears itself when sent; writing 0 does nothing.
// - periodic bit 0 sends calibration after every frame end packet.
//
// The implementer's own choice: register access over APB.
module csi_tx_port_control #(
	parameter NPORTS = 2,
	parameter NRX    = 4
) (
	// clock and reset
	input  wire              i_clk,
	input  wire              i_rst_b,
	// apb slave
	input  wire              i_psel,
	input  wire              i_penable,
	input  wire              i_pwrite,
	input  wire [11:0]       i_paddr,
	input  wire [31:0]       i_pwdata,
	output wire              o_pready,
	output reg  [31:0]       o_prdata,
	output reg               o_pslverr,
	// link clock from the phy side
	input  wire              i_link_clk,
	// receive-port video status
	input  wire [NRX-1:0]    i_rx_enabled,
	input  wire [NRX-1:0]    i_rx_valid,
	// transmitter events per port
	input  wire [NPORTS-1:0] i_frame_end_sent,
	input  wire [NPORTS-1:0] i_packet_sent,
	input  wire [NPORTS-1:0] i_line_idle,
	// per-port controls toward the transmitter
	output reg  [NPORTS-1:0] o_port_enable,
	output reg  [3*NPORTS-1:0] o_lane_count,
	output reg  [NPORTS-1:0] o_data_lp00,
	output reg  [NPORTS-1:0] o_clk_lp00,
	output reg  [NPORTS-1:0] o_clk_continuous,
	output wire [NPORTS-1:0] o_hs_hold,
	output wire [NPORTS-1:0] o_cal_active,
	output wire [NPORTS-1:0] o_cal_bit,
	output reg  [NPORTS-1:0] o_pass
);
`include "csi_tx_port_control_defs.vh"

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// lane field to active lane count
	function [2:0] lanes;
		input [1:0] f;
		begin
			lanes = 3'd4 - {1'b0, f};
		end
	endfunction

	// forced low-power field: {clock, data}; the reserved code acts as normal
	function [1:0] ulp_decode;
		input [1:0] f;
		begin
			case (f)
				2'b01:   ulp_decode = 2'b01;
				2'b11:   ulp_decode = 2'b11;
				default: ulp_decode = 2'b00;
			endcase
		end
	endfunction

	// pass over enabled receive ports, any or all
	function pass_eval;
		input           all;
		input [NRX-1:0] en;
		input [NRX-1:0] v;
		begin
			if (all)
				pass_eval = (en != {NRX{1'b0}}) && ((v & en) == en);
			else
				pass_eval = |(v & en);
		end
	endfunction

	// one port's byte out of a flattened per-port register vector
	function [7:0] port_byte;
		input [8*NPORTS-1:0] flat;
		input                port;
		begin
			port_byte = flat[8*port+:8];
		end
	endfunction

	// status view of the read-selected port
	function [7:0] status_byte;
		input pass;
		input busy;
		input port;
		begin
			status_byte                 = 8'h00;
			status_byte[`STS_PASS]      = pass;
			status_byte[`STS_CAL_BUSY]  = busy;
			status_byte[`STS_READ_PORT] = port;
		end
	endfunction

	// ----------------------------------------------------------------
	// link clock synchroniser and edge finder
	// ----------------------------------------------------------------
	reg  lclk_meta_q;
	reg  lclk_sync_q;
	reg  lclk_prev_q;
	wire link_edge;

	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lclk_meta_q <= 1'b0;
			lclk_sync_q <= 1'b0;
			lclk_prev_q <= 1'b0;
		end else begin
			lclk_meta_q <= i_link_clk;
			lclk_sync_q <= lclk_meta_q;
			lclk_prev_q <= lclk_sync_q;
		end
	end

	assign link_edge = lclk_sync_q & ~lclk_prev_q;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire [`ADDR_W-1:0] idx;
	wire               word_ok;
	wire               hit_sel;
	wire               hit_ctl;
	wire               hit_ctl2;
	wire               hit_sts;
	wire               mapped;
	wire               wr;
	wire               wr_sel;
	wire               wr_ctl;
	wire               wr_ctl2;
	wire               setup;

	assign idx      = i_paddr[11:2];
	assign word_ok  = (i_paddr[1:0] == 2'b00);
	assign hit_sel  = word_ok && (idx == {2'b00, `IDX_TX_PORT_SELECT});
	assign hit_ctl  = word_ok && (idx == {2'b00, `IDX_OUTPUT_CONTROL});
	assign hit_ctl2 = word_ok && (idx == {2'b00, `IDX_OUTPUT_CONTROL_2});
	assign hit_sts  = word_ok && (idx == {2'b00, `IDX_TX_STATUS});
	assign mapped   = hit_sel | hit_ctl | hit_ctl2 | hit_sts;
	assign setup    = i_psel & ~i_penable;
	// writes take effect at the access edge; no wait states
	assign wr       = i_psel & i_penable & i_pwrite & mapped & ~hit_sts;
	assign wr_sel   = wr & hit_sel;
	assign wr_ctl   = wr & hit_ctl;
	assign wr_ctl2  = wr & hit_ctl2;
	assign o_pready = 1'b1;

	// ----------------------------------------------------------------
	// port select register
	// ----------------------------------------------------------------
	reg  [7:0] sel_q;
	wire [7:0] sel_d;
	wire       rd_port;

	assign sel_d   = wr_sel ? (i_pwdata[7:0] & `SEL_MASK) : sel_q;
	assign rd_port = sel_q[`SEL_READ_PORT];

	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			sel_q <= `SEL_RESET;
		else
			sel_q <= sel_d;
	end

	// ----------------------------------------------------------------
	// per-port register blocks and controls
	// ----------------------------------------------------------------
	wire [8*NPORTS-1:0] ctl_flat;
	wire [8*NPORTS-1:0] ctl2_flat;
	wire [NPORTS-1:0]   en_flat;
	wire [3*NPORTS-1:0] lanes_flat;
	wire [NPORTS-1:0]   dlp_flat;
	wire [NPORTS-1:0]   clp_flat;
	wire [NPORTS-1:0]   cont_flat;
	wire [NPORTS-1:0]   pass_flat;

	genvar p;
	generate
		for (p = 0; p < NPORTS; p = p + 1) begin : g_port
			reg  [7:0] ctl_q;
			reg  [7:0] ctl2_q;
			reg  [7:0] ctl_d;
			reg  [7:0] ctl2_d;
			reg        first_pkt_q;
			wire       we;
			wire       single_done;
			wire [1:0] lane_f;
			wire [1:0] ulp_f;
			wire [1:0] ulp;
			wire       pass_now;

			// each port's block only listens when its own enable is set
			assign we = sel_q[p];

			always @* begin
				ctl_d  = ctl_q;
				ctl2_d = ctl2_q;
				if (wr_ctl && we)
					ctl_d = i_pwdata[7:0] & `CTL_MASK;
				if (single_done)
					ctl2_d[`CTL2_SINGLE] = 1'b0;
				if (wr_ctl2 && we) begin
					ctl2_d[`CTL2_PERIODIC] = i_pwdata[`CTL2_PERIODIC];
					ctl2_d[`CTL2_INVERT]   = i_pwdata[`CTL2_INVERT];
					ctl2_d[`CTL2_PASS_ALL] = i_pwdata[`CTL2_PASS_ALL];
					// write-one-to-set; a new request wins over the clear
					if (i_pwdata[`CTL2_SINGLE])
						ctl2_d[`CTL2_SINGLE] = 1'b1;
				end
			end

			always @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					ctl_q  <= `CTL_RESET;
					ctl2_q <= `CTL2_RESET;
				end else begin
					ctl_q  <= ctl_d;
					ctl2_q <= ctl2_d;
				end
			end

			// the first packet after enable arms continuous clock; disable disarms it
			always @(posedge i_clk or negedge i_rst_b) begin
				if (!i_rst_b)
					first_pkt_q <= 1'b0;
				else if (!ctl_q[`CTL_ENABLE])
					first_pkt_q <= 1'b0;
				else if (i_packet_sent[p])
					first_pkt_q <= 1'b1;
			end

			assign lane_f   = ctl_q[`CTL_LANE_LO+:2];
			assign ulp_f    = ctl_q[`CTL_ULP_LO+:2];
			assign ulp      = ulp_decode(ulp_f);
			assign pass_now = pass_eval(ctl2_q[`CTL2_PASS_ALL], i_rx_enabled, i_rx_valid);

			assign en_flat[p]         = ctl_q[`CTL_ENABLE];
			assign lanes_flat[3*p+:3] = lanes(lane_f);
			assign dlp_flat[p]        = ulp[0];
			assign clp_flat[p]        = ulp[1];
			// continuous clock drops as soon as the port is disabled
			assign cont_flat[p] = ctl_q[`CTL_CONT_CLK] & ctl_q[`CTL_ENABLE] & first_pkt_q;
			assign pass_flat[p] = ctl_q[`CTL_ENABLE] & pass_now;

			skew_cal_gen u_cal (
				.i_clk         (i_clk),
				.i_rst_b       (i_rst_b),
				.i_link_edge   (link_edge),
				.i_port_en     (ctl_q[`CTL_ENABLE]),
				.i_init_cal_en (ctl_q[`CTL_INIT_CAL]),
				.i_single_req  (ctl2_q[`CTL2_SINGLE]),
				.i_periodic_en (ctl2_q[`CTL2_PERIODIC]),
				.i_invert      (ctl2_q[`CTL2_INVERT]),
				.i_frame_end   (i_frame_end_sent[p]),
				.i_idle        (i_line_idle[p]),
				.o_busy        (o_cal_active[p]),
				.o_hs_hold     (o_hs_hold[p]),
				.o_bit         (o_cal_bit[p]),
				.o_single_done (single_done)
			);

			assign ctl_flat[8*p+:8]  = ctl_q;
			assign ctl2_flat[8*p+:8] = ctl2_q;
		end
	endgenerate

	// ----------------------------------------------------------------
	// registered controls toward the transmitter
	// ----------------------------------------------------------------
	// one process for all ports keeps each output vector single-driven
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_port_enable    <= {NPORTS{1'b0}};
			o_lane_count     <= {NPORTS{3'd4}};
			o_data_lp00      <= {NPORTS{1'b0}};
			o_clk_lp00       <= {NPORTS{1'b0}};
			o_clk_continuous <= {NPORTS{1'b0}};
			o_pass           <= {NPORTS{1'b0}};
		end else begin
			o_port_enable    <= en_flat;
			o_lane_count     <= lanes_flat;
			o_data_lp00      <= dlp_flat;
			o_clk_lp00       <= clp_flat;
			o_clk_continuous <= cont_flat;
			o_pass           <= pass_flat;
		end
	end

	// ----------------------------------------------------------------
	// read-back mux
	// ----------------------------------------------------------------
	reg  [7:0] rd_byte;
	wire [7:0] rd_ctl;
	wire [7:0] rd_ctl2;
	wire [7:0] sts;

	assign rd_ctl  = port_byte(ctl_flat, rd_port);
	assign rd_ctl2 = port_byte(ctl2_flat, rd_port);
	assign sts     = status_byte(o_pass[rd_port], o_cal_active[rd_port], rd_port);

	always @* begin
		rd_byte = 8'h00;
		if (hit_sel)
			rd_byte = sel_q;
		else if (hit_ctl)
			rd_byte = rd_ctl;
		else if (hit_ctl2)
			rd_byte = rd_ctl2;
		else if (hit_sts)
			rd_byte = sts;
	end

	// data is captured in the setup cycle and stands through the access cycle
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else if (setup) begin
			o_prdata  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			o_pslverr <= ~mapped;
		end else if (!i_psel) begin
			o_pslverr <= 1'b0;
		end
	end

endmodule // csi_tx_port_control

// ===== tb/csi_tx_port_control_sva.sv
// concurrent checks on the ports of the transmit-port control block
module csi_tx_port_control_sva #(
	parameter NPORTS = 2,
	parameter NRX    = 4
) (
	// clock, reset and apb
	input wire                i_clk,
	input wire                i_rst_b,
	input wire                i_psel,
	input wire                i_penable,
	input wire                i_pwrite,
	input wire [11:0]         i_paddr,
	input wire [31:0]         o_prdata,
	// receive status and line state
	input wire [NRX-1:0]      i_rx_enabled,
	input wire [NRX-1:0]      i_rx_valid,
	input wire [NPORTS-1:0]   i_line_idle,
	// per-port controls
	input wire [NPORTS-1:0]   o_port_enable,
	input wire [3*NPORTS-1:0] o_lane_count,
	input wire [NPORTS-1:0]   o_data_lp00,
	input wire [NPORTS-1:0]   o_clk_lp00,
	input wire [NPORTS-1:0]   o_clk_continuous,
	input wire [NPORTS-1:0]   o_hs_hold,
	input wire [NPORTS-1:0]   o_cal_active,
	input wire [NPORTS-1:0]   o_cal_bit,
	input wire [NPORTS-1:0]   o_pass
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// sequence length in clocks; the bound assumes the bench's 160 ns link clock
	logic [13:0] cal_len_q;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			cal_len_q <= 14'h0000;
		else
			cal_len_q <= o_cal_active[0] ? cal_len_q + 14'h0001 : 14'h0000;
	end
	a_lp_decode: assert property (o_clk_lp00[0] |-> o_data_lp00[0])
		else $error("clock lane forced alone");
	a_lane_range: assert property (o_lane_count[2:0] inside {[3'h1:3'h4]})
		else $error("lane count out of range");
	a_pass_none: assert property (o_port_enable[0] && $past(o_port_enable[0]) &&
		($past(i_rx_enabled & i_rx_valid) == '0) |-> !o_pass[0])
		else $error("pass without valid video");
	a_pass_all: assert property (o_port_enable[0] && $past(o_port_enable[0]) &&
		$past(i_rx_enabled) != '0 && $past(i_rx_enabled & ~i_rx_valid) == '0 |-> o_pass[0])
		else $error("pass missing with all ports valid");
	a_cal_len: assert property ($fell(o_cal_active[0]) |->
		cal_len_q inside {[14'h1fd6:14'h2008]})
		else $error("calibration length wrong");
	a_cal_toggle: assert property (o_cal_active[0] && $past(o_cal_active[0]) &&
		$changed(o_cal_bit[0]) |=> (!o_cal_active[0] || $stable(o_cal_bit[0])) [*4])
		else $error("pattern bit toggled too fast");
	a_cal_idle: assert property ($rose(o_cal_active[0]) && !o_hs_hold[0] |->
		$past(i_line_idle[0]))
		else $error("calibration started while busy");
	a_cont_needs_en: assert property (o_clk_continuous[0] |-> o_port_enable[0])
		else $error("continuous clock on disabled port");
	a_rd_upper: assert property (i_psel && i_penable && !i_pwrite |->
		o_prdata[31:8] == '0)
		else $error("upper read bits not zero");
	a_rsvd_ctl2: assert property (i_psel && i_penable && !i_pwrite &&
		i_paddr == 12'h0d0 |-> o_prdata[7:4] == '0)
		else $error("reserved bits read nonzero");
endmodule // csi_tx_port_control_sva

bind csi_tx_port_control csi_tx_port_control_sva #(.NPORTS(NPORTS), .NRX(NRX))
	csi_tx_port_control_sva_inst (.*);

// ===== tb/csi_rx_model.sv
// far-side model: link clock, transmitter events and line idle state
module csi_rx_model (
	// clock and commands from the bench
	input  wire logic  i_clk,
	input  wire logic  i_run,
	input  wire logic  i_fe,
	input  wire logic  i_pkt,
	// toward the block
	output logic       o_link_clk,
	output logic [1:0] o_frame_end,
	output logic [1:0] o_packet,
	output logic [1:0] o_idle
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_link_clk = 1'b0;
	// link clock runs only while the bench holds i_run set, and stands still otherwise
	always #80 if (i_run) o_link_clk = ~o_link_clk;
	always @(posedge i_clk) begin
		o_frame_end <= {2{i_fe}};
		o_packet    <= {2{i_pkt}};
		// line is busy only while an event is being sent
		o_idle      <= {2{~(i_fe | i_pkt)}};
	end
endmodule // csi_rx_model

// ===== tb/test_csi_tx_port_control.sv
// top testbench: apb register tests and calibration runs
`include "csi_tx_port_control_defs.vh"
module test_csi_tx_port_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SEL = `IDX_TX_PORT_SELECT;
	localparam logic [7:0] CTL = `IDX_OUTPUT_CONTROL;
	localparam logic [7:0] CT2 = `IDX_OUTPUT_CONTROL_2;
	localparam logic [7:0] STS = `IDX_TX_STATUS;
	logic        i_clk, i_rst_b, psel, penable, pwrite, pready, pslverr, run, fe, pkt, link, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  rx_en, rx_val;
	logic [1:0]  fe_s, pkt_s, idle, port_en, dlp, clp, cont, hold, cal_act, cal_bit, pass;
	logic [5:0]  lanes;
	logic [7:0]  q;
	int          fail_count, comparisons;
	csi_tx_port_control csi_tx_port_control_inst (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
		.o_prdata(prdata), .o_pslverr(pslverr), .i_link_clk(link), .i_rx_enabled(rx_en),
		.i_rx_valid(rx_val), .i_frame_end_sent(fe_s), .i_packet_sent(pkt_s),
		.i_line_idle(idle), .o_port_enable(port_en), .o_lane_count(lanes),
		.o_data_lp00(dlp), .o_clk_lp00(clp), .o_clk_continuous(cont), .o_hs_hold(hold),
		.o_cal_active(cal_act), .o_cal_bit(cal_bit), .o_pass(pass));
	csi_rx_model csi_rx_model_inst (
		.i_clk(i_clk), .i_run(run), .i_fe(fe), .i_pkt(pkt),
		.o_link_clk(link), .o_frame_end(fe_s), .o_packet(pkt_s), .o_idle(idle));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, x);
		comparisons++;
		if (g !== x) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, x);
		end
	endtask
	// read data and error are taken at the edge that samples pready
	task automatic apb(input logic w, input logic [7:0] a, d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, a, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge i_clk);
		penable <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			@(posedge i_clk);
			if (pready === 1'b1) begin
				q = prdata[7:0];
				e = pslverr;
				psel <= 1'b0;
				penable <= 1'b0;
				return;
			end
		end
		fail_count++;
		give_verdict();
	endtask
	task automatic wr(input logic [7:0] a, d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, x);
		apb(1'b0, a, 8'h00);
		chk(q, x);
	endtask
	task automatic settle();
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic wait_cal(input logic v);
		for (int n = 0; n < 20000; n++) begin
			@(posedge i_clk);
			#1;
			if (cal_act[0] === v) return;
		end
		fail_count++;
		give_verdict();
	endtask
	task automatic pulse(input logic f);
		@(posedge i_clk);
		fe <= f;
		pkt <= !f;
		@(posedge i_clk);
		fe <= 1'b0;
		pkt <= 1'b0;
	endtask
	initial begin
		i_rst_b = 1'b0;
		{psel, penable, pwrite, run, fe, pkt} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		rx_en = 4'b0011;
		rx_val = 4'b0100;
		repeat (20) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rd(SEL, 8'h00);
		rd(CTL, 8'h00);
		rd(CT2, 8'h00);
		$display("test reset_values done");
		wr(SEL, 8'hff);
		rd(SEL, 8'h13);
		wr(SEL, 8'h01);
		wr(CTL, 8'h15);
		wr(SEL, 8'h10);
		rd(CTL, 8'h00);
		wr(CTL, 8'h2a);
		wr(SEL, 8'h00);
		rd(CTL, 8'h15);
		wr(SEL, 8'h13);
		wr(CTL, 8'hbf);
		rd(CTL, 8'h3f);
		wr(SEL, 8'h03);
		rd(CTL, 8'h3f);
		apb(1'b0, 8'h40, 8'h00);
		chk({e, q}, 9'h100);
		$display("test port_select done");
		for (int c = 0; c < 4; c++) begin
			wr(CTL, 8'(c * 20));
			settle();
			chk({lanes[2:0], dlp[0], clp[0]}, {3'(4 - c), c[0], c == 3});
		end
		wr(CTL, 8'h01);
		settle();
		chk(port_en, 2'b11);
		chk(pass, 2'b00);
		@(posedge i_clk);
		rx_val <= 4'b0001;
		settle();
		chk(pass, 2'b11);
		rd(STS, 8'h01);
		wr(CT2, 8'h08);
		settle();
		chk(pass, 2'b00);
		@(posedge i_clk);
		rx_val <= 4'b0011;
		settle();
		chk(pass, 2'b11);
		wr(CTL, 8'h00);
		settle();
		chk(port_en, 2'b00);
		$display("test fields done");
		wr(CTL, 8'h03);
		settle();
		chk(cont, 2'b00);
		pulse(1'b0);
		settle();
		settle();
		chk(cont, 2'b11);
		wr(CT2, 8'h00);
		wr(CTL, 8'h40);
		run <= 1'b1;
		wr(CTL, 8'h41);
		wait_cal(1'b1);
		chk({hold[0], cal_bit[0]}, 2'b10);
		wait_cal(1'b0);
		settle();
		chk(hold[0], 1'b0);
		wr(CT2, 8'h06);
		wait_cal(1'b1);
		chk(cal_bit[0], 1'b1);
		wr(CT2, 8'h04);
		rd(CT2, 8'h06);
		rd(STS, 8'h05);
		wait_cal(1'b0);
		settle();
		rd(CT2, 8'h04);
		wr(CT2, 8'h01);
		pulse(1'b1);
		wait_cal(1'b1);
		chk(cal_bit[0], 1'b0);
		wait_cal(1'b0);
		run <= 1'b0;
		$display("test calibration done");
		give_verdict();
	end
endmodule // test_csi_tx_port_control
